// *** core/fbm_mode_reg.sv ***
// fbm_mode_reg.sv: first mode configuration register, wishbone slave
// assumes: classic wishbone master on clk_i, 8-bit data, byte addresses;
// irq_req_i, uart and telegram inputs from logic on the same clock
`include "fbm_defs.svh"

module fbm_mode_reg
   import fbm_pkg::*;
#(
   parameter int EOI_LONG_CYC   = `FBM_EOI_LONG_CYC,
   parameter int UTMR_SHORT_CYC = `FBM_UTMR_SHORT_CYC,
   parameter int UTMR_LONG_CYC  = `FBM_UTMR_LONG_CYC
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // wishbone slave
   input  wire logic       cyc_i,
   input  wire logic       stb_i,
   input  wire logic       we_i,
   input  wire logic [7:0] adr_i,
   input  wire logic [0:0] sel_i,
   input  wire logic [7:0] dat_i,
   output logic      [7:0] dat_o,
   output logic            ack_o,
   output logic            err_o,
   // receiver, telegram and interrupt request events
   input  wire logic       rx_start_bad_i,
   input  wire logic       rx_stop_bad_i,
   input  wire logic       prm_valid_i,
   input  wire logic [1:0] prm_bits_i,
   input  wire logic       dx_state_i,
   input  wire logic       out_tel_i,
   input  wire logic       out_len_zero_i,
   input  wire logic       irq_req_i,
   // decoded controls and status
   output logic            rx_frame_err_o,
   output logic            tel_accept_o,
   output logic            bcast_rx_en_o,
   output logic            resp_delay_combi_o,
   output logic            cyc_slave_en_o,
   output logic            prm_direct_o,
   output logic            irq_o,
   output logic            utmr_tick_o,
   output logic            online_o
);
   localparam int EOI_SHORT_CYC = `FBM_EOI_SHORT_CYC;

   fbm_mode_t   mode_q;
   fbm_bus_st_t st_q;
   logic        go_q;
   logic        err_q;
   logic [31:0] eoi_cnt_q;
   logic [31:0] utmr_cnt_q;
   logic        irq_act_q;

   function automatic logic [15:0] merge_byte(input logic [15:0] cur, input logic hi,
                                              input logic [7:0] d);
      logic [15:0] m;
      m = hi ? {d, cur[7:0]} : {cur[15:8], d};
      return (m & `FBM_MODE_WMASK) | (cur & ~`FBM_MODE_WMASK & 16'h0004);
   endfunction : merge_byte

   // either byte of the mode register
   function automatic logic is_mode_adr(input logic [7:0] a);
      return (a == `FBM_OFF_MODE_LO) || (a == `FBM_OFF_MODE_HI);
   endfunction : is_mode_adr

   wire req      = cyc_i && stb_i && sel_i[0];
   wire hit_lo   = adr_i == `FBM_OFF_MODE_LO;
   wire hit_hi   = adr_i == `FBM_OFF_MODE_HI;
   wire hit_ctl  = adr_i == `FBM_OFF_CTRL;
   wire hit_sts  = adr_i == `FBM_OFF_STATUS;
   wire mapped   = hit_lo || hit_hi || hit_ctl || hit_sts;
   wire take     = req && (mode_q.early_rdy ? st_q == FBM_IDLE : st_q == FBM_WAIT);
   // writes to mode bytes are dropped while online, flagged in status
   wire wr_mode  = take && we_i && is_mode_adr(adr_i) && !go_q;

   // bus sequencer: one wait state unless early ready
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= FBM_IDLE;
      end else begin
         case (st_q)
            FBM_IDLE: if (req) st_q <= mode_q.early_rdy ? FBM_ACK : FBM_WAIT;
            FBM_WAIT: st_q <= FBM_ACK;
            FBM_ACK:  st_q <= FBM_IDLE;
            default:  st_q <= FBM_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         err_o <= 1'b0;
         dat_o <= 8'h00;
      end else begin
         ack_o <= take && mapped;
         err_o <= take && !mapped;
         if (take) begin
            case (1'b1)
               hit_lo:  dat_o <= mode_q[7:0];
               hit_hi:  dat_o <= {2'b00, mode_q[13:8]};
               hit_ctl: dat_o <= {7'h00, go_q};
               hit_sts: dat_o <= {7'h00, err_q};
               default: dat_o <= 8'h00;
            endcase
         end
      end
   end

   // mode register; telegram overwrite wins over a host write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= fbm_mode_t'(`FBM_MODE_RST);
      end else begin
         if (wr_mode) begin
            mode_q <= fbm_mode_t'(merge_byte(mode_q, hit_hi, dat_i));
         end
         if (prm_valid_i && mode_q.cyc_en) begin
            mode_q.start_dis <= prm_bits_i[0];
            mode_q.stop_dis  <= prm_bits_i[1];
         end
      end
   end

   // go bit and online write error flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         go_q  <= 1'b0;
         err_q <= 1'b0;
      end else begin
         if (take && we_i && hit_ctl) go_q <= dat_i[0];
         if (take && we_i && hit_sts && dat_i[0]) err_q <= 1'b0;
         if (take && we_i && is_mode_adr(adr_i) && go_q) err_q <= 1'b1;
      end
   end

   // decoded control outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_frame_err_o     <= 1'b0;
         tel_accept_o       <= 1'b0;
         bcast_rx_en_o      <= 1'b0;
         resp_delay_combi_o <= 1'b0;
         cyc_slave_en_o     <= 1'b0;
         prm_direct_o       <= 1'b0;
         online_o           <= 1'b0;
      end else begin
         rx_frame_err_o <= (rx_start_bad_i && !mode_q.start_dis)
                        || (rx_stop_bad_i && !mode_q.stop_dis);
         tel_accept_o   <= dx_state_i && out_tel_i
                        && (!out_len_zero_i || mode_q.clr_mode);
         bcast_rx_en_o      <= mode_q.bcast_en;
         resp_delay_combi_o <= mode_q.resp_dly;
         cyc_slave_en_o     <= mode_q.cyc_en && go_q;
         prm_direct_o       <= mode_q.sprm_buf;
         online_o           <= go_q;
      end
   end

   // interrupt output with minimum inactive time after each request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_act_q <= 1'b0;
         eoi_cnt_q <= 32'h0000_0000;
      end else if (irq_act_q) begin
         if (!irq_req_i) begin
            irq_act_q <= 1'b0;
            eoi_cnt_q <= 32'(mode_q.eoi_base ? EOI_LONG_CYC : EOI_SHORT_CYC);
         end
      end else if (eoi_cnt_q != 32'h0000_0000) begin
         eoi_cnt_q <= eoi_cnt_q - 32'h0000_0001;
      end else if (irq_req_i) begin
         irq_act_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) irq_o <= 1'b1;
      else irq_o <= irq_act_q ~^ mode_q.irq_pol;
   end

   // checker helper: cycles since the request went inactive, saturating
   logic [31:0] gap_cnt_q;
   logic        gap_long_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gap_cnt_q  <= 32'hFFFF_FFFF;
         gap_long_q <= 1'b0;
      end else if (irq_act_q) begin
         gap_cnt_q  <= 32'h0000_0000;
         gap_long_q <= mode_q.eoi_base;
      end else if (gap_cnt_q != 32'hFFFF_FFFF) begin
         gap_cnt_q <= gap_cnt_q + 32'h0000_0001;
      end
   end

   // user timer tick
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         utmr_cnt_q  <= 32'h0000_0000;
         utmr_tick_o <= 1'b0;
      end else begin
         utmr_tick_o <= 1'b0;
         if (!go_q) begin
            utmr_cnt_q <= 32'h0000_0000;
         end else if (utmr_cnt_q >= (mode_q.utmr_base ? UTMR_LONG_CYC - 1
                                                      : UTMR_SHORT_CYC - 1)) begin
            utmr_cnt_q  <= 32'h0000_0000;
            utmr_tick_o <= 1'b1;
         end else begin
            utmr_cnt_q <= utmr_cnt_q + 32'h0000_0001;
         end
      end
   end

   chk_offline_write: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && we_i && hit_lo && go_q) |=> $stable(mode_q[7:0]))
      else $error("mode written while online");
   chk_prm_overwrite: assert property (@(posedge clk_i) disable iff (rst_i)
      (prm_valid_i && mode_q.cyc_en) |=> mode_q.start_dis == $past(prm_bits_i[0]))
      else $error("telegram overwrite missed");
   chk_start_mon: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_start_bad_i && !mode_q.start_dis) |=> rx_frame_err_o)
      else $error("start error not reported");
   chk_stop_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rx_start_bad_i && mode_q.stop_dis) |=> !rx_frame_err_o)
      else $error("stop check not masked");
   chk_bcast_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      !mode_q.bcast_en) else $error("broadcast enabled");
   chk_resp_dly: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 resp_delay_combi_o == $past(mode_q.resp_dly)) else $error("delay select wrong");
   chk_irq_pol: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 irq_o == ($past(irq_act_q) ~^ $past(mode_q.irq_pol))) else $error("irq level wrong");
   chk_zero_len: assert property (@(posedge clk_i) disable iff (rst_i)
      (dx_state_i && out_tel_i && out_len_zero_i && !mode_q.clr_mode) |=> !tel_accept_o)
      else $error("zero length accepted");
   chk_early_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && st_q == FBM_IDLE && mode_q.early_rdy && mapped) |=> ack_o)
      else $error("early ready late");
   chk_late_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      (req && st_q == FBM_IDLE && !mode_q.early_rdy) |=> !ack_o ##1 (ack_o || err_o))
      else $error("normal ready timing wrong");
   chk_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_q[15:14] == 2'b00) else $error("unused bits set");
   chk_eoi_gap: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(irq_act_q) |=> !irq_act_q [*8]) else $error("inactive time short");
   chk_eoi_min: assert property (@(posedge clk_i) disable iff (rst_i)
      (!irq_act_q && irq_req_i
       && gap_cnt_q < 32'(gap_long_q ? EOI_LONG_CYC : EOI_SHORT_CYC)) |=> !irq_act_q)
      else $error("inactive time cut");
   chk_wr_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && we_i && hit_lo && !go_q && !prm_valid_i)
      |=> mode_q[7:0] == ($past(dat_i) & 8'hFB)) else $error("low byte write lost");
   chk_hi_lands: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && we_i && hit_hi && !go_q) |=> mode_q[13:8] == $past(dat_i[5:0]))
      else $error("high byte write lost");
   chk_hi_offline: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && we_i && hit_hi && go_q) |=> $stable(mode_q[13:8]))
      else $error("high byte written while online");
   chk_sts_set: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && we_i && is_mode_adr(adr_i) && go_q) |=> err_q)
      else $error("online write not flagged");
   chk_go_ctl: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && we_i && hit_ctl) |=> go_q == $past(dat_i[0])) else $error("go bit lost");
   chk_online_out: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 online_o == $past(go_q)) else $error("online output wrong");
   chk_prm_stop: assert property (@(posedge clk_i) disable iff (rst_i)
      (prm_valid_i && mode_q.cyc_en) |=> mode_q.stop_dis == $past(prm_bits_i[1]))
      else $error("stop overwrite missed");
   chk_prm_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (prm_valid_i && !mode_q.cyc_en && !wr_mode) |=> $stable(mode_q[1:0]))
      else $error("telegram overwrite outside mode");
   chk_stop_mon: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_stop_bad_i && !mode_q.stop_dis) |=> rx_frame_err_o)
      else $error("stop error not reported");
   chk_start_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      (!rx_stop_bad_i && mode_q.start_dis) |=> !rx_frame_err_o)
      else $error("start check not masked");
   chk_bcast_out: assert property (@(posedge clk_i) disable iff (rst_i)
      !bcast_rx_en_o) else $error("broadcast path on");
   chk_zero_take: assert property (@(posedge clk_i) disable iff (rst_i)
      (dx_state_i && out_tel_i && mode_q.clr_mode) |=> tel_accept_o)
      else $error("clear mode telegram dropped");
   chk_prm_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 prm_direct_o == $past(mode_q.sprm_buf)) else $error("buffer mode wrong");
   chk_lo_read: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && !we_i && hit_lo) |=> dat_o == $past(mode_q[7:0]))
      else $error("low byte read wrong");
   chk_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
      (take && !mapped) |=> err_o && !ack_o) else $error("unmapped not refused");
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o) else $error("ack held too long");
   chk_cyc_en: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 cyc_slave_en_o == ($past(mode_q.cyc_en) && $past(go_q)))
      else $error("cyclic slave enable wrong");
   chk_tick_off: assert property (@(posedge clk_i) disable iff (rst_i)
      !go_q |=> !utmr_tick_o) else $error("tick while offline");
   chk_tick_short: assert property (@(posedge clk_i) disable iff (rst_i)
      (go_q && !mode_q.utmr_base && utmr_cnt_q == 32'(UTMR_SHORT_CYC - 1)) |=> utmr_tick_o)
      else $error("short tick missed");
   chk_tick_long: assert property (@(posedge clk_i) disable iff (rst_i)
      (go_q && mode_q.utmr_base && utmr_cnt_q == 32'(UTMR_LONG_CYC - 1)) |=> utmr_tick_o)
      else $error("long tick missed");
   chk_ack_excl: assert property (@(posedge clk_i) disable iff (rst_i)
      !(ack_o && err_o)) else $error("ack and err together");

   cov_online: cover property (@(posedge clk_i) $rose(go_q));
   cov_prm: cover property (@(posedge clk_i) prm_valid_i && mode_q.cyc_en);
   cov_tick: cover property (@(posedge clk_i) utmr_tick_o);
   cov_early: cover property (@(posedge clk_i) ack_o && mode_q.early_rdy);
   cov_refused: cover property (@(posedge clk_i) err_o);
endmodule : fbm_mode_reg

// *** core/fbm_defs.svh ***
// fbm_defs.svh: offsets, field positions, reset values and timing counts
// assumes: included by the mode register core, not by the package
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH
`define FBM_OFF_MODE_LO    8'h06
`define FBM_OFF_MODE_HI    8'h07
`define FBM_OFF_CTRL       8'h08
`define FBM_OFF_STATUS     8'h09
`define FBM_BIT_START_DIS  0
`define FBM_BIT_STOP_DIS   1
`define FBM_BIT_BCAST_EN   2
`define FBM_BIT_RESP_DLY   3
`define FBM_BIT_IRQ_POL    4
`define FBM_BIT_EARLY_RDY  5
`define FBM_BIT_SYNC_SUP   6
`define FBM_BIT_FRZ_SUP    7
`define FBM_BIT_CYC_EN     8
`define FBM_BIT_EOI_BASE   9
`define FBM_BIT_UTMR_BASE  10
`define FBM_BIT_WATCHDOG_TEST_SELECT    11
`define FBM_BIT_SPRM_BUF   12
`define FBM_BIT_CLR_MODE   13
`define FBM_MODE_WMASK     16'h3FFB
`define FBM_MODE_RST       16'h0000
`define FBM_CLK_MHZ        250
`define FBM_EOI_SHORT_US   1
`define FBM_EOI_LONG_MS    1
`define FBM_UTMR_SHORT_MS  1
`define FBM_UTMR_LONG_MS   10
`define FBM_EOI_SHORT_CYC  (`FBM_EOI_SHORT_US * `FBM_CLK_MHZ)
`define FBM_EOI_LONG_CYC   (`FBM_EOI_LONG_MS * 1000 * `FBM_CLK_MHZ)
`define FBM_UTMR_SHORT_CYC (`FBM_UTMR_SHORT_MS * 1000 * `FBM_CLK_MHZ)
`define FBM_UTMR_LONG_CYC  (`FBM_UTMR_LONG_MS * 1000 * `FBM_CLK_MHZ)
`endif

// *** core/fbm_pkg.sv ***
// fbm_pkg.sv: types of the mode configuration register block
// assumes: fbm_defs.svh on the include path
package fbm_pkg;
   typedef struct packed {
      logic [1:0]  zero;
      logic        clr_mode;
      logic        sprm_buf;
      logic        watchdog_test_select;
      logic        utmr_base;
      logic        eoi_base;
      logic        cyc_en;
      logic        frz_sup;
      logic        sync_sup;
      logic        early_rdy;
      logic        irq_pol;
      logic        resp_dly;
      logic        bcast_en;
      logic        stop_dis;
      logic        start_dis;
   } fbm_mode_t;

   typedef struct packed {
      logic        start_dis;
      logic        stop_dis;
   } fbm_prm_t;

   typedef enum logic [2:0] {
      FBM_IDLE = 3'b001,
      FBM_WAIT = 3'b010,
      FBM_ACK  = 3'b100
   } fbm_bus_st_t;
endpackage : fbm_pkg

// *** verification/fbm_host.sv ***
// fbm_host.sv: host processor model, classic wishbone master
// assumes: slave on the same clk_i, answers with ack or err
module fbm_host
   import fbm_pkg::*;
(
   // clock and answer
   input  wire logic       clk_i,
   input  wire logic       ack_i,
   input  wire logic       err_i,
   input  wire logic [7:0] dat_i,
   // request
   output logic            cyc_o,
   output logic            stb_o,
   output logic      [0:0] sel_o,
   output logic            we_o,
   output logic      [7:0] adr_o,
   output logic      [7:0] dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {cyc_o, stb_o, sel_o, we_o, adr_o, dat_o} = '0;
   end
   // one cycle; t_online also writes a mode byte after go is set
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] q, output int lat, output logic e);
      lat = 0;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      sel_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      dat_o <= d;
      // no cap here: only the bench watchdog ends a hang
      do begin
         @(posedge clk_i);
         lat++;
      end while (ack_i !== 1'b1 && err_i !== 1'b1);
      q = dat_i;
      e = err_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      sel_o <= 1'b0;
      we_o  <= 1'b0;
      // idle gap before any next request
      @(posedge clk_i);
   endtask : xfer
endmodule : fbm_host

// *** verification/fbm_mode_reg_tb.sv ***
// fbm_mode_reg_tb.sv: self-checking bench of the mode register block
// assumes: fbm_host drives the bus; short timer counts for simulation
module fbm_mode_reg_tb
   import fbm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cyc, stb, we, ack, err, sbad, pbad, pval, dx, otel, olz, ireq;
   logic       ferr, tacc, bce, rdc, cse, pdir, irq, tick, onl, e;
   logic [7:0] adr, wd, rd, q;
   logic [1:0] pbits;
   logic [0:0] sel;
   int         lat, error_cnt, check_count;
   fbm_host host_u (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rd), .cyc_o(cyc),
      .stb_o(stb), .sel_o(sel), .we_o(we), .adr_o(adr), .dat_o(wd));
   fbm_mode_reg #(.EOI_LONG_CYC(20), .UTMR_SHORT_CYC(30), .UTMR_LONG_CYC(60)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wd), .dat_o(rd), .ack_o(ack), .err_o(err),
      .rx_start_bad_i(sbad), .rx_stop_bad_i(pbad), .prm_valid_i(pval),
      .prm_bits_i(pbits), .dx_state_i(dx), .out_tel_i(otel), .out_len_zero_i(olz),
      .irq_req_i(ireq), .rx_frame_err_o(ferr), .tel_accept_o(tacc), .bcast_rx_en_o(bce),
      .resp_delay_combi_o(rdc), .cyc_slave_en_o(cse), .prm_direct_o(pdir), .irq_o(irq),
      .utmr_tick_o(tick), .online_o(onl));
   always #2 clk_i = ~clk_i;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_u.xfer(1'b1, a, d, q, lat, e);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      host_u.xfer(1'b0, a, 8'h00, q, lat, e);
   endtask : rdr
   // one-cycle event pulse, then look for a response within three edges
   task automatic pulse(input int which, output logic seen);
      seen = 1'b0;
      @(posedge clk_i);
      case (which)
         0: sbad <= 1'b1;
         1: pbad <= 1'b1;
         2: otel <= 1'b1;
         default: pval <= 1'b1;
      endcase
      @(posedge clk_i);
      {sbad, pbad, otel, pval} <= 4'h0;
      repeat (3) begin
         @(posedge clk_i);
         seen = seen | (which == 2 ? tacc === 1'b1 : ferr === 1'b1);
      end
   endtask : pulse
   task automatic t_reset;
      rdr(8'h06);
      chk(q, 8'h00);
      chk(lat[7:0], 8'h03);
      chk(irq, 1'b1);
      rdr(8'h07);
      chk(q, 8'h00);
   endtask : t_reset
   task automatic t_fields;
      wr(8'h06, 8'hFF);
      rdr(8'h06);
      chk(q, 8'hFB);
      chk(lat[7:0], 8'h02);
      wr(8'h07, 8'hF7);
      rdr(8'h07);
      chk(q, 8'h37);
      chk({bce, rdc, pdir}, 8'h03);
      chk(irq, 1'b0);
      ireq <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(irq, 1'b1);
      ireq <= 1'b0;
   endtask : t_fields
   task automatic t_monitor;
      logic s;
      pulse(0, s);
      chk(s, 1'b0);
      pulse(1, s);
      chk(s, 1'b0);
      // bit0, bit1 and early ready cleared; high-active irq kept
      wr(8'h06, 8'h10);
      pulse(0, s);
      chk(s, 1'b1);
      pulse(1, s);
      chk(s, 1'b1);
   endtask : t_monitor
   task automatic t_tel;
      logic s;
      dx <= 1'b1;
      olz <= 1'b1;
      pulse(2, s);
      chk(s, 1'b1);
      wr(8'h07, 8'h01);
      pulse(2, s);
      chk(s, 1'b0);
   endtask : t_tel
   task automatic t_online;
      logic s;
      chk(cse, 1'b0);
      wr(8'h08, 8'h01);
      chk({onl, cse}, 8'h03);
      wr(8'h06, 8'hFF);
      rdr(8'h06);
      chk(q, 8'h10);
      rdr(8'h09);
      chk(q[0], 1'b1);
      pbits <= 2'b11;
      pulse(3, s);
      rdr(8'h06);
      chk(q, 8'h13);
      rdr(8'h40);
      chk(e, 1'b1);
   endtask : t_online
   task automatic t_timer;
      int n;
      n = 0;
      repeat (100) begin
         @(posedge clk_i);
         if (tick === 1'b1) break;
      end
      do begin
         @(posedge clk_i);
         n++;
      end while (tick !== 1'b1 && n < 200);
      chk(n[7:0], 8'd30);
   endtask : t_timer
   // high-active irq, short inactive time of 250 cycles at least
   task automatic t_irq;
      int n;
      n = 0;
      ireq <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (irq !== 1'b1 && n < 50);
      ireq <= 1'b0;
      do begin
         @(posedge clk_i);
         n++;
      end while (irq !== 1'b0 && n < 100);
      ireq <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (irq !== 1'b1 && n < 1000);
      chk(n >= 250 && n < 1000, 1'b1);
      ireq <= 1'b0;
   endtask : t_irq
   // reset in mid-run brings back offline state and reset values
   task automatic t_rerst;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk({onl, cse}, 8'h00);
      chk(irq, 1'b1);
      rdr(8'h06);
      chk(q, 8'h00);
      chk(lat[7:0], 8'h03);
   endtask : t_rerst
   task automatic summarize;
      $display("checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      {clk_i, sbad, pbad, pval, dx, otel, olz, ireq, pbits} = '0;
      {error_cnt, check_count} = '0;
      rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_fields();
      t_monitor();
      t_tel();
      t_online();
      t_timer();
      t_irq();
      t_rerst();
      summarize();
   end
   // watchdog: whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end
endmodule : fbm_mode_reg_tb
